// ---- hdl/cme_pkg.sv ----
// Shared types, constants and bit-type maps for the config management and error block
package cme_pkg;

  localparam int unsigned CME_ADDR_W     = 10;
  localparam int unsigned CME_DATA_W     = 32;
  localparam int unsigned CME_BE_W       = 4;
  localparam int unsigned CME_HDR_LOG_W  = 128;
  localparam int unsigned CME_CPL_HDR_W  = 48;
  localparam int unsigned CME_CFG_WORDS  = 1024;
  localparam int unsigned CME_FIFO_DEPTH = 4;
  localparam int unsigned CME_LOG_WORDS  = 4;

  // Dword indices of the modelled configuration words
  localparam logic [9:0] CME_IDX_ID       = 10'h000;
  localparam logic [9:0] CME_IDX_CMD_STAT = 10'h001;
  localparam logic [9:0] CME_IDX_CLASS    = 10'h002;
  localparam logic [9:0] CME_IDX_UE_STAT  = 10'h041;
  localparam logic [9:0] CME_IDX_CE_STAT  = 10'h044;
  localparam logic [9:0] CME_IDX_HDR_LOG  = 10'h047;

  // Status bit positions set by error reports
  localparam int unsigned CME_UE_BIT_CPL_TIMEOUT = 14;
  localparam int unsigned CME_UE_BIT_CPL_ABORT   = 15;
  localparam int unsigned CME_UE_BIT_UNEXP_CPL   = 16;
  localparam int unsigned CME_UE_BIT_ECRC        = 19;
  localparam int unsigned CME_UE_BIT_UNSUP_REQ   = 20;
  localparam int unsigned CME_UE_BIT_ACS         = 21;
  localparam int unsigned CME_CE_BIT_CORR        = 0;
  localparam int unsigned CME_ST_BIT_SIG_ABORT   = 27;

  // Identity word value is arbitrary
  localparam logic [31:0] CME_ID_RESET    = 32'h0001_0002;
  localparam logic [31:0] CME_WORD_RESET  = 32'h0000_0000;
  localparam logic [31:0] CME_MASK_NONE   = 32'h0000_0000;
  localparam logic [31:0] CME_MASK_ALL    = 32'hFFFF_FFFF;
  localparam logic [31:0] CME_MASK_HI16   = 32'hFFFF_0000;

  typedef enum logic {CME_IDLE, CME_DONE} cme_mgmt_st_t;

  typedef struct packed {
    logic [6:0]  lower_addr;
    logic [11:0] byte_count;
    logic [2:0]  tc;
    logic [1:0]  attr;
    logic [15:0] requester_id;
    logic [7:0]  tag;
  } cme_cpl_hdr_t;

  typedef struct packed {
    cme_cpl_hdr_t hdr;
    logic         locked;
    logic         is_abort;
  } cme_cpl_req_t;

  // Bits never writable from the user port: identity word and header log words
  function automatic logic [31:0] cme_fixed_mask(input logic [9:0] a);
    if (a == CME_IDX_ID) return CME_MASK_ALL;
    else if (a >= CME_IDX_HDR_LOG && a < CME_IDX_HDR_LOG + 10'h004) return CME_MASK_ALL;
    else return CME_MASK_NONE;
  endfunction

  function automatic logic [31:0] cme_ro_mask(input logic [9:0] a);
    if (a == CME_IDX_CLASS) return CME_MASK_ALL;
    else return CME_MASK_NONE;
  endfunction

  function automatic logic [31:0] cme_w1c_mask(input logic [9:0] a);
    if (a == CME_IDX_CMD_STAT) return CME_MASK_HI16;
    else if (a == CME_IDX_UE_STAT || a == CME_IDX_CE_STAT) return CME_MASK_ALL;
    else return CME_MASK_NONE;
  endfunction

endpackage

// ---- hdl/cme_top.sv ----
// Configuration management port and error reporting port, device side
// What this block does
// R1: Active-low 4-bit byte enables pick which bytes of the dword take part.
// R2: User supplies 32-bit write data for configuration writes.
// R3: Device returns 32-bit configuration read data.
// R4: User addresses each access with a 10-bit dword address.
// R5: Read requested by driving read enable low.
// R6: Write requested by driving write enable low.
// R7: Done pulses low on completion; read data valid only while done.
// R8: Read-only override lets a write change read-only bits, not fixed ones.
// R9: Clear-bit override treats write-one-to-clear bits as read-write.
// R10: Otherwise writing one clears such a bit; only internal events set it.
// R11: User drives access violation input low to report it.
// R12: 128-bit header log is accepted when an error is signalled.
// R13: User drives correctable error input low to report it.
// R14: Completion abort report ignored while header FIFO is not ready.
// R15: FIFO ready asserted low when the completion header FIFO has room.
// R16: User drives completion timeout input low to report it.
// R17: User drives unexpected completion input low to report it.
// R18: User drives end-to-end CRC error input low to report it.
// R19: Locked qualifier makes the owed completion a locked completion.
// R20: Posted qualifier marks the failing transaction posted; no completion owed.
// R21: User supplies 48-bit completion header in the fixed field layout.
// R22: Unsupported request report ignored while header FIFO is not ready.
// R23: User holds a request stable until done; one access at a time.
`timescale 1ns/1ps
module cme_top
  import cme_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = cme_pkg::CME_FIFO_DEPTH
)(
  input  wire logic                 clock_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 ce_i,
  input  wire logic [3:0]           mgmt_byte_enable_n_i,
  input  wire logic [31:0]          mgmt_write_data_i,
  output logic      [31:0]          mgmt_read_data_o,
  input  wire logic [9:0]           mgmt_dword_address_i,
  input  wire logic                 mgmt_read_enable_n_i,
  input  wire logic                 mgmt_write_enable_n_i,
  output logic                      mgmt_access_done_n_o,
  input  wire logic                 write_readonly_override_n_i,
  input  wire logic                 write_clearbit_override_n_i,
  input  wire logic                 err_access_violation_n_i,
  input  wire logic [127:0]         err_header_log_data_i,
  output logic                      err_header_log_set_n_o,
  input  wire logic                 err_correctable_n_i,
  input  wire logic                 err_completion_abort_n_i,
  output logic                      err_header_fifo_ready_n_o,
  input  wire logic                 err_completion_timeout_n_i,
  input  wire logic                 err_unexpected_completion_n_i,
  input  wire logic                 err_end_to_end_crc_n_i,
  input  wire logic                 err_locked_qualifier_n_i,
  input  wire logic                 err_posted_qualifier_n_i,
  input  wire logic                 err_unsupported_request_n_i,
  input  wire cme_pkg::cme_cpl_hdr_t err_completion_header_i,
  output logic                      cpl_valid_o,
  input  wire logic                 cpl_ready_i,
  output cme_pkg::cme_cpl_req_t     cpl_req_o
);
  import cme_pkg::*;

  localparam int unsigned PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  typedef struct packed {
    cme_mgmt_st_t st;
    logic [31:0]  rd_data;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]  count;
  } cme_state_t;

  cme_state_t   s_r;
  cme_state_t   s_nxt;
  logic [31:0]  cfg_mem [CME_CFG_WORDS];
  cme_cpl_req_t cpl_mem [FIFO_DEPTH];

  logic         take;
  logic         wr_take;
  logic [31:0]  old_word;
  logic [31:0]  be_mask;
  logic [31:0]  wmask;
  logic [31:0]  w1c_val;
  logic [31:0]  new_val;
  logic [31:0]  wr_word;
  logic         room;
  logic         ur_ok;
  logic         ca_ok;
  logic         any_err;
  logic         push;
  logic         pop;
  logic [31:0]  ue_set;
  logic [31:0]  ce_set;
  logic [31:0]  st_set;
  cme_cpl_req_t push_entry;

  // Management access: one access per request, done one cycle after it is taken
  always_comb
  begin
    take     = (s_r.st == CME_IDLE) && (!mgmt_read_enable_n_i || !mgmt_write_enable_n_i); // R5 R6
    wr_take  = take && !mgmt_write_enable_n_i;
    old_word = cfg_mem[mgmt_dword_address_i]; // R4
    for (int b = 0; b < CME_BE_W; b++)
    begin
      be_mask[8*b +: 8] = {8{~mgmt_byte_enable_n_i[b]}}; // R1
    end
    // A one written to a clear-type bit clears it unless the override is active
    w1c_val = !write_clearbit_override_n_i ? mgmt_write_data_i
                                           : (old_word & ~mgmt_write_data_i); // R9 R10
    new_val = (mgmt_write_data_i & ~cme_w1c_mask(mgmt_dword_address_i))
            | (w1c_val & cme_w1c_mask(mgmt_dword_address_i)); // R2
    // Fixed bits stay out even under the read-only override
    wmask   = be_mask & ~cme_fixed_mask(mgmt_dword_address_i)
            & ~(cme_ro_mask(mgmt_dword_address_i) & {32{write_readonly_override_n_i}}); // R8
    wr_word = (old_word & ~wmask) | (new_val & wmask);
  end

  // Error reports: UR and abort need FIFO room, the rest are always taken
  always_comb
  begin
    room    = (s_r.count < (PW+1)'(FIFO_DEPTH));
    ur_ok   = !err_unsupported_request_n_i && room; // R22
    ca_ok   = !err_completion_abort_n_i && room; // R14
    any_err = ur_ok || ca_ok || !err_completion_timeout_n_i || !err_unexpected_completion_n_i
           || !err_end_to_end_crc_n_i || !err_access_violation_n_i || !err_correctable_n_i;
    ue_set  = '0;
    ue_set[CME_UE_BIT_UNSUP_REQ]   = ur_ok;
    ue_set[CME_UE_BIT_CPL_ABORT]   = ca_ok;
    ue_set[CME_UE_BIT_CPL_TIMEOUT] = !err_completion_timeout_n_i; // R16
    ue_set[CME_UE_BIT_UNEXP_CPL]   = !err_unexpected_completion_n_i; // R17
    ue_set[CME_UE_BIT_ECRC]        = !err_end_to_end_crc_n_i; // R18
    ue_set[CME_UE_BIT_ACS]         = !err_access_violation_n_i; // R11
    ce_set  = '0;
    ce_set[CME_CE_BIT_CORR]        = !err_correctable_n_i; // R13
    st_set  = '0;
    st_set[CME_ST_BIT_SIG_ABORT]   = ca_ok;
    // Posted requests owe no completion, so nothing is queued for them
    push    = (ur_ok || ca_ok) && err_posted_qualifier_n_i; // R20
    push_entry.hdr      = err_completion_header_i; // R21
    push_entry.locked   = !err_locked_qualifier_n_i; // R19
    push_entry.is_abort = ca_ok && !ur_ok;
    pop     = cpl_valid_o && cpl_ready_i;
  end

  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      CME_IDLE:
        if (take)
        begin
          s_nxt.st      = CME_DONE;
          s_nxt.rd_data = old_word; // R3
        end
      CME_DONE: s_nxt.st = CME_IDLE;
      default:  s_nxt.st = CME_IDLE;
    endcase
    if (push)
    begin
      s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      s_nxt.count = s_r.count + 1'b1;
    end
    else if (pop && !push)
    begin
      s_nxt.count = s_r.count - 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_r <= '{st: CME_IDLE, rd_data: '0, wr_ptr: '0, rd_ptr: '0, count: '0};
    end
    else if (ce_i)
    begin
      s_r <= s_nxt;
    end
  end

  // Internal sets are applied after the user write so a set in the clear cycle wins
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < CME_CFG_WORDS; i++)
      begin
        cfg_mem[i] <= (i == 0) ? CME_ID_RESET : CME_WORD_RESET;
      end
    end
    else if (ce_i)
    begin
      if (wr_take)
      begin
        cfg_mem[mgmt_dword_address_i] <= wr_word;
      end
      if (any_err)
      begin
        for (int k = 0; k < CME_LOG_WORDS; k++)
        begin
          cfg_mem[CME_IDX_HDR_LOG + 10'(k)] <= err_header_log_data_i[32*k +: 32]; // R12
        end
      end
      cfg_mem[CME_IDX_UE_STAT] <= ((wr_take && mgmt_dword_address_i == CME_IDX_UE_STAT)
                                   ? wr_word : cfg_mem[CME_IDX_UE_STAT]) | ue_set; // R10
      cfg_mem[CME_IDX_CE_STAT] <= ((wr_take && mgmt_dword_address_i == CME_IDX_CE_STAT)
                                   ? wr_word : cfg_mem[CME_IDX_CE_STAT]) | ce_set;
      cfg_mem[CME_IDX_CMD_STAT] <= ((wr_take && mgmt_dword_address_i == CME_IDX_CMD_STAT)
                                    ? wr_word : cfg_mem[CME_IDX_CMD_STAT]) | st_set;
    end
  end

  // Completion header FIFO storage; no reset needed, guarded by count
  always_ff @(posedge clock_i)
  begin
    if (ce_i && push)
    begin
      cpl_mem[s_r.wr_ptr] <= push_entry;
    end
  end

  assign mgmt_access_done_n_o      = (s_r.st != CME_DONE); // R7
  assign mgmt_read_data_o          = s_r.rd_data;
  assign err_header_fifo_ready_n_o = !room; // R15
  assign err_header_log_set_n_o    = 1'b0;
  assign cpl_valid_o               = (s_r.count != '0);
  assign cpl_req_o                 = cpl_mem[s_r.rd_ptr];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i || !ce_i);

  chk_done_after_take: assert property (take |=> !mgmt_access_done_n_o) // R7
    else $error("done did not follow a taken access");
  chk_done_one_cycle: assert property (!mgmt_access_done_n_o |=> mgmt_access_done_n_o) // R7
    else $error("done held longer than one cycle");
  chk_read_data_value: assert property (take |=> mgmt_read_data_o == $past(old_word)) // R3
    else $error("read data does not match addressed word");
  chk_fifo_ready_full: assert property (err_header_fifo_ready_n_o // R15
                                        == (s_r.count == (PW+1)'(FIFO_DEPTH)))
    else $error("fifo ready does not reflect fullness");
  chk_ur_ignored: assert property (err_header_fifo_ready_n_o && !err_unsupported_request_n_i // R22
                                   |=> s_r.count == $past(s_r.count) - (PW+1)'($past(pop)))
    else $error("unsupported request queued while fifo not ready");
  chk_ca_ignored: assert property (err_header_fifo_ready_n_o && !err_completion_abort_n_i // R14
                                   |=> s_r.count == $past(s_r.count) - (PW+1)'($past(pop)))
    else $error("abort queued while fifo not ready");
  chk_lock_flag: assert property (push && !err_locked_qualifier_n_i // R19
                                  |=> cpl_mem[$past(s_r.wr_ptr)].locked)
    else $error("locked qualifier lost");
  chk_posted_nopush: assert property (!err_posted_qualifier_n_i |-> !push) // R20
    else $error("posted error queued a completion");
  chk_ro_protect: assert property (wr_take && mgmt_dword_address_i == CME_IDX_CLASS // R8
                                   && write_readonly_override_n_i
                                   |=> cfg_mem[CME_IDX_CLASS] == $past(cfg_mem[CME_IDX_CLASS]))
    else $error("read-only word changed without override");
  chk_w1c_set: assert property (wr_take && mgmt_dword_address_i == CME_IDX_CE_STAT // R9
                                && !write_clearbit_override_n_i && mgmt_byte_enable_n_i == 4'h0
                                |=> cfg_mem[CME_IDX_CE_STAT] == ($past(mgmt_write_data_i)
                                                                 | $past(ce_set)))
    else $error("clear-bit override write not stored");
  chk_w1c_clear: assert property (wr_take && mgmt_dword_address_i == CME_IDX_CE_STAT // R10
                                  && write_clearbit_override_n_i && ce_set == '0
                                  && mgmt_byte_enable_n_i == 4'h0
                                  |=> (cfg_mem[CME_IDX_CE_STAT] & $past(mgmt_write_data_i)) == '0)
    else $error("write of one did not clear bit");
  chk_byte_lane: assert property (wr_take && mgmt_dword_address_i == CME_IDX_CMD_STAT // R1
                                  && mgmt_byte_enable_n_i[0]
                                  |=> cfg_mem[CME_IDX_CMD_STAT][7:0]
                                      == $past(cfg_mem[CME_IDX_CMD_STAT][7:0]))
    else $error("disabled byte lane was written");
  chk_hdr_log: assert property (any_err |=> cfg_mem[CME_IDX_HDR_LOG] // R12
                                == $past(err_header_log_data_i[31:0]))
    else $error("header log not captured");

  cov_read:     cover property (take && !mgmt_read_enable_n_i ##1 !mgmt_access_done_n_o);
  cov_write:    cover property (wr_take ##1 !mgmt_access_done_n_o);
  cov_ur_push:  cover property (push && !err_unsupported_request_n_i);
  cov_fifo_full: cover property (err_header_fifo_ready_n_o && !err_completion_abort_n_i);

endmodule // cme_top

// ---- verification/cme_drain_model.sv ----
// Drain model for the owed-completion port, standing in for the user logic
`timescale 1ns/1ps
module cme_drain_model
(
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic stall_i,
  input  wire logic cpl_valid_i,
  output logic      cpl_ready_o,
  output int        pops_o
);
  // Ready is the inverse of stall so the bench can back the FIFO up until it refuses
  assign cpl_ready_o = !stall_i;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pops_o <= 0;
    else if (cpl_valid_i && cpl_ready_o)
      pops_o <= pops_o + 1;
  end
endmodule // cme_drain_model

// ---- verification/tb.sv ----
// Self-checking bench for the config management and error reporting block
`timescale 1ns/1ps
module tb;
  import cme_pkg::*;
  logic         clock_i;
  logic         rst_n_i;
  logic         stall;
  logic         ce;
  logic         ur_n;
  logic [3:0]   be_n;
  logic [31:0]  wdata;
  logic [31:0]  rdata;
  logic [9:0]   addr;
  logic         rd_n;
  logic         wr_n;
  logic         done_n;
  logic         ro_n;
  logic         c1_n;
  logic         lk_n;
  logic         po_n;
  logic         set_n;
  logic         fifo_n;
  logic         cv;
  logic         crdy;
  logic [5:0]   err_n;
  logic [127:0] hlog;
  cme_cpl_hdr_t hdr;
  cme_cpl_req_t creq;
  int           pops;
  int           num_errors;
  int           n_compared;

  cme_top #(.FIFO_DEPTH(4)) i_cme_top (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .err_unsupported_request_n_i(ur_n),
    .mgmt_byte_enable_n_i(be_n), .mgmt_write_data_i(wdata), .mgmt_read_data_o(rdata),
    .mgmt_dword_address_i(addr), .mgmt_read_enable_n_i(rd_n), .mgmt_write_enable_n_i(wr_n),
    .mgmt_access_done_n_o(done_n), .write_readonly_override_n_i(ro_n),
    .write_clearbit_override_n_i(c1_n), .err_access_violation_n_i(err_n[0]),
    .err_header_log_data_i(hlog), .err_header_log_set_n_o(set_n),
    .err_correctable_n_i(err_n[1]), .err_completion_abort_n_i(err_n[2]),
    .err_header_fifo_ready_n_o(fifo_n), .err_completion_timeout_n_i(err_n[3]),
    .err_unexpected_completion_n_i(err_n[4]), .err_end_to_end_crc_n_i(err_n[5]),
    .err_locked_qualifier_n_i(lk_n), .err_posted_qualifier_n_i(po_n),
    .err_completion_header_i(hdr), .cpl_valid_o(cv), .cpl_ready_i(crdy), .cpl_req_o(creq));

  cme_drain_model i_cme_drain_model (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .stall_i(stall), .cpl_valid_i(cv),
    .cpl_ready_o(crdy), .pops_o(pops));

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request through the edge at which done is sampled low, then lets go
  task automatic access(input logic w, input logic [9:0] a, input logic [3:0] b,
                        input logic [31:0] d, input logic r, input logic c,
                        output logic [31:0] q);
    int i;
    @(posedge clock_i);
    #1;
    {addr, be_n, wdata, ro_n, c1_n} = {a, b, d, r, c};
    rd_n = w;
    wr_n = !w;
    for (i = 0; i < 8 && done_n !== 1'b0; i++)
    begin
      @(posedge clock_i);
      #1;
    end
    if (done_n !== 1'b0)
    begin
      num_errors++;
      print_verdict();
    end
    @(posedge clock_i);
    q = rdata;
    #1;
    {rd_n, wr_n, ro_n, c1_n, be_n} = 8'hFF;
  endtask

  task automatic wr(input logic [9:0] a, input logic [3:0] b, input logic [31:0] d,
                    input logic r, input logic c);
    logic [31:0] q;
    access(1'b1, a, b, d, r, c, q);
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 4'h0, 32'h0000_0000, 1'b1, 1'b1, q);
    check({32'h0000_0000, q}, {32'h0000_0000, exp});
  endtask

  task automatic pulse(input logic [5:0] e, input logic l, input logic p);
    @(posedge clock_i);
    #1;
    {err_n, lk_n, po_n} = {e, l, p};
    @(posedge clock_i);
    #1;
    {err_n, lk_n, po_n} = 8'hFF;
  endtask

  task automatic pulse_ur(input logic [5:0] e);
    @(posedge clock_i);
    #1;
    {ur_n, err_n} = {1'b0, e};
    @(posedge clock_i);
    #1;
    {ur_n, err_n} = 7'h7F;
  endtask

  task automatic t_reset();
    check(64'(done_n), 64'h1);
    check(64'(fifo_n), 64'h0);
    check(64'(cv), 64'h0);
    check(64'(set_n), 64'h0);
    rdchk(CME_IDX_ID, CME_ID_RESET);
    $display("test reset done");
  endtask

  task automatic t_rw();
    wr(10'h010, 4'h0, 32'hAABB_CCDD, 1'b1, 1'b1);
    wr(10'h010, 4'hA, 32'h1122_3344, 1'b1, 1'b1);
    wr(10'h3FF, 4'h0, 32'h5A5A_A5A5, 1'b1, 1'b1);
    wr(CME_IDX_CMD_STAT, 4'h0, 32'h0000_00AB, 1'b1, 1'b1);
    wr(CME_IDX_CMD_STAT, 4'h1, 32'h0000_1234, 1'b1, 1'b1);
    rdchk(CME_IDX_CMD_STAT, 32'h0000_12AB);
    rdchk(10'h010, 32'hAA22_CC44);
    rdchk(10'h3FF, 32'h5A5A_A5A5);
    $display("test byte enables done");
  endtask

  task automatic t_ro();
    wr(CME_IDX_CLASS, 4'h0, 32'h1234_5678, 1'b1, 1'b1);
    rdchk(CME_IDX_CLASS, 32'h0000_0000);
    wr(CME_IDX_CLASS, 4'h0, 32'h1234_5678, 1'b0, 1'b1);
    rdchk(CME_IDX_CLASS, 32'h1234_5678);
    wr(CME_IDX_ID, 4'h0, 32'hFFFF_FFFF, 1'b0, 1'b1);
    rdchk(CME_IDX_ID, CME_ID_RESET);
    $display("test read-only override done");
  endtask

  task automatic t_err();
    int i;
    logic [5:0] one [4] = '{6'h3E, 6'h37, 6'h2F, 6'h1F};
    hlog = 128'hDEAD_BEEF_0123_4567_89AB_CDEF_F00D_CAFE;
    for (i = 0; i < 4; i++)
      pulse(one[i], 1'b1, 1'b1);
    rdchk(CME_IDX_UE_STAT, 32'h0029_4000);
    pulse(6'h3D, 1'b1, 1'b1);
    rdchk(CME_IDX_CE_STAT, 32'h0000_0001);
    rdchk(CME_IDX_HDR_LOG, hlog[31:0]);
    rdchk(CME_IDX_HDR_LOG + 10'h003, hlog[127:96]);
    $display("test error reports done");
  endtask

  task automatic t_w1c();
    wr(CME_IDX_CE_STAT, 4'h0, 32'h0000_0001, 1'b1, 1'b1);
    rdchk(CME_IDX_CE_STAT, 32'h0000_0000);
    wr(CME_IDX_CE_STAT, 4'h0, 32'hFFFF_FFFF, 1'b1, 1'b0);
    rdchk(CME_IDX_CE_STAT, 32'hFFFF_FFFF);
    wr(CME_IDX_CE_STAT, 4'h0, 32'h0000_00F0, 1'b1, 1'b1);
    rdchk(CME_IDX_CE_STAT, 32'hFFFF_FF0F);
    $display("test clear-bit override done");
  endtask

  task automatic t_fifo();
    int i;
    stall = 1'b1;
    hdr = 48'hBEEF_0000_0001;
    pulse(6'h3B, 1'b1, 1'b0);
    check(64'(cv), 64'h0);
    for (i = 0; i < 4; i++)
    begin
      hdr = 48'hA000_0000_1200 + 48'(i);
      pulse(6'h3B, i != 0, 1'b1);
    end
    check(64'(fifo_n), 64'h1);
    check(64'(creq), {14'h0000, 48'hA000_0000_1200, 2'b11});
    // Full FIFO: this abort must leave no entry behind
    pulse(6'h3B, 1'b1, 1'b1);
    pulse_ur(6'h3F);
    stall = 1'b0;
    for (i = 0; i < 20 && cv !== 1'b0; i++)
      @(posedge clock_i);
    #1;
    check(64'(pops), 64'h4);
    check(64'(fifo_n), 64'h0);
    rdchk(CME_IDX_UE_STAT, 32'h0029_C000);
    // Unsupported request and abort together queue one entry, not an abort
    stall = 1'b1;
    hdr = 48'h1234_5678_9ABC;
    pulse_ur(6'h3B);
    check(64'(creq), {14'h0000, 48'h1234_5678_9ABC, 2'b00});
    stall = 1'b0;
    for (i = 0; i < 20 && cv !== 1'b0; i++)
      @(posedge clock_i);
    #1;
    check(64'(pops), 64'h5);
    rdchk(CME_IDX_UE_STAT, 32'h0039_C000);
    rdchk(CME_IDX_CMD_STAT, 32'h0800_12AB);
    $display("test completion FIFO done");
  endtask

  // A report in the very cycle of a clearing write must survive it
  task automatic t_ce();
    fork
      wr(CME_IDX_UE_STAT, 4'h0, 32'hFFFF_FFFF, 1'b1, 1'b1);
      pulse(6'h37, 1'b1, 1'b1);
    join
    rdchk(CME_IDX_UE_STAT, 32'h0000_4000);
    ce = 1'b0;
    pulse(6'h1F, 1'b1, 1'b1);
    ce = 1'b1;
    rdchk(CME_IDX_UE_STAT, 32'h0000_4000);
    $display("test set-wins and clock enable done");
  endtask

  initial
  begin
    {rst_n_i, stall, rd_n, wr_n, ro_n, c1_n, lk_n, po_n} = 8'h7F;
    {be_n, err_n, wdata, addr, hlog} = '1;
    hdr = 48'h0000_0000_0000;
    ce = 1'b1;
    ur_n = 1'b1;
    num_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_rw();
    t_ro();
    t_err();
    t_w1c();
    t_fifo();
    t_ce();
    print_verdict();
  end
endmodule // tb
